// *** design/aio_pkg.sv ***
// Purpose: Shared constants and types of the analog I/O link map
// Assumes: 32-bit link words, four inputs and four outputs
// Notes: Link indices are zero based (link 1 is index 0)
package aio_pkg;
   ////////////////////////////////////////////////////////////////////////
   // Link layout
   localparam int LW_NUM = 16;
   localparam int LW_W = 32;
   localparam int CH_NUM = 4;
   localparam int LK_IN_DATA = 0;
   localparam int LK_OUT_ECHO = 4;
   localparam int LK_IN_STAT = 8;
   localparam int LK_OUT_STAT = 9;
   localparam int LK_CARD_STAT = 10;
   localparam int RX_CMD = 0;
   localparam int RX_RELEASE = 4;
   ////////////////////////////////////////////////////////////////////////
   // Status fields
   localparam int FLD_W = 8;
   localparam int FL_N = 4;
   localparam int IF_WIRE_BREAK = 0;
   localparam int IF_ABOVE = 1;
   localparam int IF_BELOW = 2;
   localparam int IF_INVALID = 3;
   localparam int OF_EXT_N = 6;
   localparam int OF_INVALID_FLOAT = 6;
   localparam logic [LW_W-1:0] STAT_RST = 32'h0000_0000;
   localparam logic [LW_W-1:0] DEF_VAL_RST = 32'h0000_0000;
   ////////////////////////////////////////////////////////////////////////
   // Channel setup
   localparam int MODE_EN = 0;
   localparam int MODE_4_20 = 1;
   localparam logic [1:0] CFG_MODE_RST = 2'h0;
   localparam logic [15:0] CFG_LO_RST = 16'h0000;
   localparam logic [15:0] CFG_HI_RST = 16'hFFFF;
   localparam logic [15:0] WB_SET_UA = 16'h07D0;
   localparam logic [15:0] WB_CLR_UA = 16'h0BB8;
   ////////////////////////////////////////////////////////////////////////
   // Float fields
   localparam int FP_EXP_MSB = 30;
   localparam int FP_EXP_LSB = 23;
   localparam int FP_MAN_MSB = 22;

   typedef enum logic [1:0] {AIO_OFFLINE = 2'b01, AIO_ONLINE = 2'b10} aio_conn_t;

   function automatic logic aio_is_nan(input logic [LW_W-1:0] v);
   begin
      return (&v[FP_EXP_MSB:FP_EXP_LSB]) && (|v[FP_MAN_MSB:0]);
   end
   endfunction : aio_is_nan
endpackage : aio_pkg

// *** design/aio_in_chan.sv ***
// Purpose: Status flags of one input channel
// Assumes: Readings and loop current arrive with a sample strobe
// Notes: Flags follow live conditions unless latching is on
module aio_in_chan
   import aio_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic sample_i,
   input wire logic [15:0] loop_ua_i,
   input wire logic [15:0] code_i,
   input wire logic cfg_wr_i,
   input wire logic [15:0] cfg_lo_i,
   input wire logic [15:0] cfg_hi_i,
   input wire logic [1:0] cfg_mode_i,
   input wire logic latch_en_i,
   input wire logic [FL_N-1:0] release_i,
   output logic [FLD_W-1:0] flags_o
);
   typedef struct packed {
      logic [15:0] lo;
      logic [15:0] hi;
      logic [1:0] mode;
      logic [FL_N-1:0] cond;
      logic [FL_N-1:0] flags;
   } aio_chan_t;

   localparam aio_chan_t CHAN_RST = '{lo: CFG_LO_RST, hi: CFG_HI_RST,
      mode: CFG_MODE_RST, default: '0};

   aio_chan_t s_r;
   aio_chan_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      if (cfg_wr_i)
      begin
         if (cfg_lo_i < cfg_hi_i)
         begin
            s_nxt.lo = cfg_lo_i;
            s_nxt.hi = cfg_hi_i;
            s_nxt.mode = cfg_mode_i;
            s_nxt.cond[IF_INVALID] = 1'b0;
         end
         else
         begin
            s_nxt.cond[IF_INVALID] = 1'b1;
         end
      end
      if (!s_r.mode[MODE_EN])
      begin
         s_nxt.cond[IF_WIRE_BREAK] = 1'b0;
         s_nxt.cond[IF_ABOVE] = 1'b0;
         s_nxt.cond[IF_BELOW] = 1'b0;
      end
      else if (sample_i)
      begin
         if (loop_ua_i < WB_SET_UA)
            s_nxt.cond[IF_WIRE_BREAK] = 1'b1;
         else if (loop_ua_i > WB_CLR_UA)
            s_nxt.cond[IF_WIRE_BREAK] = 1'b0;
         s_nxt.cond[IF_ABOVE] = code_i >= s_r.hi;
         s_nxt.cond[IF_BELOW] = code_i <= s_r.lo;
      end
      if (!s_r.mode[MODE_4_20])
         s_nxt.cond[IF_WIRE_BREAK] = 1'b0;
      // Live condition always sets; latched bit needs release
      s_nxt.flags = s_nxt.cond | (s_r.flags & {FL_N{latch_en_i}} & ~release_i);
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         s_r <= CHAN_RST;
      else
         s_r <= s_nxt;
   end

   assign flags_o = {{(FLD_W-FL_N){1'b0}}, s_r.flags};

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   AST_WB_SET:
   assert property (sample_i && !cfg_wr_i && (s_r.mode == 2'h3) && loop_ua_i < WB_SET_UA
      |=> flags_o[IF_WIRE_BREAK]) else $error("wire break not flagged");
   AST_WB_0_20:
   assert property (!s_r.mode[MODE_4_20] |=> !s_r.cond[IF_WIRE_BREAK])
      else $error("wire break in 0-20 range");
   AST_ABOVE:
   assert property (sample_i && !cfg_wr_i && s_r.mode[MODE_EN]
      |=> s_r.cond[IF_ABOVE] == ($past(code_i) >= $past(s_r.hi)))
      else $error("above limit flag wrong");
   AST_BELOW:
   assert property (sample_i && !cfg_wr_i && s_r.mode[MODE_EN]
      |=> s_r.cond[IF_BELOW] == ($past(code_i) <= $past(s_r.lo)))
      else $error("below limit flag wrong");
   AST_BAD_CFG:
   assert property (cfg_wr_i && cfg_lo_i >= cfg_hi_i
      |=> flags_o[IF_INVALID] && $stable(s_r.hi) && $stable(s_r.lo))
      else $error("bad setup not flagged or applied");
   AST_LATCH:
   assert property (latch_en_i && s_r.flags[IF_ABOVE] && !release_i[IF_ABOVE]
      |=> s_r.flags[IF_ABOVE]) else $error("latched flag lost");
endmodule : aio_in_chan

// *** design/aio_link_map.sv ***
// Purpose: Link word exchange between the analog I/O card and the drive
// Assumes: Host link words are delivered as one set with link_wr_i
// Notes: Output commands come from stored default values until host commands replace them
// Behaviour
// - Sixteen 32-bit words each way
// - Links 1-4 readings, 5-8 output echoes
// - Links 9-11 status, 12-16 unused
// - Incoming links 1-4 command the outputs
// - Incoming link 5 releases latched status
// - Before connection, outputs use stored defaults
// - Connected commands overwrite stored defaults
// - Link loss keeps last received command until reconfigured
// - Data words float, status words bit fields
// - Input status: 8-bit field per channel
// - Wire break below 2 mA, clears above 3 mA
// - Wire break detection follows channel scan
// - Above limit flag at or over high limit
// - Below limit flag at or under low limit
// - Bad setup flagged, last valid setup kept
// - Output status: 8-bit field per channel
module aio_link_map
   import aio_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic conn_up_i,
   input wire logic link_wr_i,
   input wire logic [LW_NUM*LW_W-1:0] link_from_host_i,
   output logic [LW_NUM*LW_W-1:0] link_to_host_o,
   input wire logic def_wr_i,
   input wire logic [1:0] def_idx_i,
   input wire logic [LW_W-1:0] def_data_i,
   input wire logic [CH_NUM-1:0] ain_valid_i,
   input wire logic [CH_NUM*LW_W-1:0] ain_data_i,
   input wire logic [CH_NUM*16-1:0] ain_code_i,
   input wire logic [CH_NUM*16-1:0] loop_ua_i,
   input wire logic [CH_NUM-1:0] cfg_wr_i,
   input wire logic [15:0] cfg_lo_i,
   input wire logic [15:0] cfg_hi_i,
   input wire logic [1:0] cfg_mode_i,
   input wire logic latch_en_i,
   input wire logic [CH_NUM*OF_EXT_N-1:0] out_flags_i,
   input wire logic [LW_W-1:0] card_stat_i,
   output logic [CH_NUM*LW_W-1:0] aout_cmd_o,
   output logic online_o
);
   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      aio_conn_t conn;
      logic [CH_NUM-1:0][LW_W-1:0] out_val;
      logic [CH_NUM-1:0][LW_W-1:0] in_val;
      logic [CH_NUM-1:0] bad_float;
      logic [LW_W-1:0] out_stat;
      logic [LW_W-1:0] card_stat;
      logic [LW_W-1:0] release_w;
   } aio_map_t;

   localparam aio_map_t MAP_RST = '{conn: AIO_OFFLINE,
      out_val: {CH_NUM{DEF_VAL_RST}}, in_val: {CH_NUM{DEF_VAL_RST}},
      bad_float: '0, out_stat: STAT_RST, card_stat: STAT_RST, release_w: STAT_RST};

   aio_map_t s_r;
   aio_map_t s_nxt;
   logic [LW_W-1:0] in_stat;
   logic [LW_W-1:0] rx_word;
   logic rx_take;

   ////////////////////////////////////////////////////////////////////////
   // Input channel status
   genvar g;
   generate
      for (g = 0; g < CH_NUM; g++)
      begin : gen_in
         aio_in_chan u_chan (
            .clk_sys_i(clk_sys_i),
            .nrst_i(nrst_i),
            .sample_i(ain_valid_i[g]),
            .loop_ua_i(loop_ua_i[g*16 +: 16]),
            .code_i(ain_code_i[g*16 +: 16]),
            .cfg_wr_i(cfg_wr_i[g]),
            .cfg_lo_i(cfg_lo_i),
            .cfg_hi_i(cfg_hi_i),
            .cfg_mode_i(cfg_mode_i),
            .latch_en_i(latch_en_i),
            .release_i(s_r.release_w[g*FLD_W +: FL_N]),
            .flags_o(in_stat[g*FLD_W +: FLD_W])
         );
      end
   endgenerate

   // Host words count only on a configured connection
   assign rx_take = (s_r.conn == AIO_ONLINE) && conn_up_i && link_wr_i;

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.release_w = STAT_RST;
      rx_word = STAT_RST;
      case (s_r.conn)
         AIO_OFFLINE:
         begin
            if (conn_up_i)
               s_nxt.conn = AIO_ONLINE;
         end
         AIO_ONLINE:
         begin
            if (!conn_up_i)
               s_nxt.conn = AIO_OFFLINE;
         end
         default:
         begin
            s_nxt.conn = AIO_OFFLINE;
         end
      endcase
      // Setup writes fill the stored defaults
      if (def_wr_i && !aio_is_nan(def_data_i))
         s_nxt.out_val[def_idx_i] = def_data_i;
      if (rx_take)
      begin
         for (int i = 0; i < CH_NUM; i++)
         begin
            rx_word = link_from_host_i[(RX_CMD+i)*LW_W +: LW_W];
            if (aio_is_nan(rx_word))
            begin
               s_nxt.bad_float[i] = 1'b1;
            end
            else
            begin
               s_nxt.out_val[i] = rx_word;
               s_nxt.bad_float[i] = 1'b0;
            end
         end
         // Words beyond the release word are not looked at
         s_nxt.release_w = link_from_host_i[RX_RELEASE*LW_W +: LW_W];
      end
      for (int i = 0; i < CH_NUM; i++)
      begin
         if (ain_valid_i[i])
            s_nxt.in_val[i] = ain_data_i[i*LW_W +: LW_W];
         s_nxt.out_stat[i*FLD_W +: FLD_W] =
            {1'b0, s_nxt.bad_float[i], out_flags_i[i*OF_EXT_N +: OF_EXT_N]};
      end
      s_nxt.card_stat = card_stat_i;
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         s_r <= MAP_RST;
      else
         s_r <= s_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Host-facing words
   always_comb
   begin
      link_to_host_o = '0;
      for (int i = 0; i < CH_NUM; i++)
      begin
         link_to_host_o[(LK_IN_DATA+i)*LW_W +: LW_W] = s_r.in_val[i];
         link_to_host_o[(LK_OUT_ECHO+i)*LW_W +: LW_W] = s_r.out_val[i];
      end
      link_to_host_o[LK_IN_STAT*LW_W +: LW_W] = in_stat;
      link_to_host_o[LK_OUT_STAT*LW_W +: LW_W] = s_r.out_stat;
      link_to_host_o[LK_CARD_STAT*LW_W +: LW_W] = s_r.card_stat;
   end

   assign aout_cmd_o = s_r.out_val;
   assign online_o = s_r.conn == AIO_ONLINE;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   AST_OFFLINE_DEFAULT:
   assert property (!rx_take && !def_wr_i |=> $stable(aout_cmd_o))
      else $error("outputs moved without command");
   AST_CMD_APPLIED:
   assert property (rx_take && !aio_is_nan(link_from_host_i[LW_W-1:0])
      |=> aout_cmd_o[LW_W-1:0] == $past(link_from_host_i[LW_W-1:0]))
      else $error("command not applied");
   AST_NAN_HOLD:
   assert property (rx_take && aio_is_nan(link_from_host_i[LW_W-1:0])
      |=> $stable(aout_cmd_o[LW_W-1:0]) ##1
      link_to_host_o[LK_OUT_STAT*LW_W+OF_INVALID_FLOAT])
      else $error("invalid float not held or flagged");
   AST_ECHO:
   assert property (link_to_host_o[LK_OUT_ECHO*LW_W +: CH_NUM*LW_W] == aout_cmd_o)
      else $error("echo mismatch");
   AST_UNUSED:
   assert property (link_to_host_o[LW_NUM*LW_W-1:(LK_CARD_STAT+1)*LW_W] == '0)
      else $error("unused link not zero");
   AST_RESERVED:
   assert property ((in_stat & 32'hF0F0_F0F0) == 32'h0000_0000)
      else $error("reserved input status bit set");
   AST_READING:
   assert property (ain_valid_i[1]
      |=> link_to_host_o[(LK_IN_DATA+1)*LW_W +: LW_W] == $past(ain_data_i[LW_W +: LW_W]))
      else $error("reading not forwarded");
   AST_NO_RX_OFFLINE:
   assert property (!online_o |=> s_r.release_w == '0)
      else $error("host word taken while offline");
endmodule : aio_link_map

// *** dv/aio_host_model.sv ***
// Purpose: Drive controller that hands link word sets to the card
// Assumes: One set per call, taken at the edge after it is driven
// Notes: Unused words carry changing noise; words are inverted after the pulse
module aio_host_model
   import aio_pkg::*;
(
   input wire logic clk_sys_i,
   output logic link_wr_o,
   output logic [LW_NUM*LW_W-1:0] link_from_host_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int unsigned noise = 32'h5A5A_0001;
   initial
   begin
      link_wr_o = 1'b0;
      link_from_host_o = '0;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic send(input logic [CH_NUM*LW_W-1:0] cmd, input logic [LW_W-1:0] rel);
      int k;
      begin
         @(posedge clk_sys_i);
         #1;
         link_wr_o = 1'b1;
         link_from_host_o[CH_NUM*LW_W-1:0] = cmd;
         link_from_host_o[RX_RELEASE*LW_W +: LW_W] = rel;
         for (k = RX_RELEASE + 1; k < LW_NUM; k++)
            link_from_host_o[k*LW_W +: LW_W] = noise ^ k;
         noise = noise * 32'h0019_660D + 32'h3C6E_F35F;
         @(posedge clk_sys_i);
         #1;
         link_wr_o = 1'b0;
         link_from_host_o = ~link_from_host_o;
      end
   endtask : send
endmodule : aio_host_model

// *** dv/aio_link_map_bench.sv ***
// Purpose: Self-checking bench of the analog I/O link map
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Random commands and readings from a fixed seed
module aio_link_map_bench
   import aio_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] LO = 16'h1000;
   localparam logic [15:0] HI = 16'hE000;
   logic clk_sys_i = 1'b0, nrst_i = 1'b0, conn_up_i = 1'b0, def_wr_i = 1'b0, latch_en_i = 1'b0;
   logic link_wr_i, online_o;
   logic [1:0] def_idx_i = 2'h0, cfg_mode_i = 2'h3;
   logic [15:0] cfg_lo_i = LO, cfg_hi_i = HI;
   logic [CH_NUM-1:0] ain_valid_i = 4'h0, cfg_wr_i = 4'h0;
   logic [LW_W-1:0] def_data_i = 32'h0, card_stat_i = 32'h0;
   logic [LW_NUM*LW_W-1:0] link_from_host_i, link_to_host_o;
   logic [CH_NUM*LW_W-1:0] ain_data_i = '0, aout_cmd_o, cmd;
   logic [CH_NUM*16-1:0] ain_code_i = '0, loop_ua_i = '0;
   logic [CH_NUM*OF_EXT_N-1:0] out_flags_i = '0;
   int failures = 0, n_tests = 0, seed = 32'h1B0F, k, n;
   logic [15:0] tcode [6] = '{16'h8000, 16'h8000, HI, LO, 16'h8000, 16'h8000};
   logic [15:0] tua [6] = '{16'h03E8, 16'h09C4, 16'h0DAC, 16'h0DAC, 16'h07CF, 16'h0BB9};
   logic tbrk [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

   always #4 clk_sys_i = ~clk_sys_i;
   aio_link_map uut (.clk_sys_i, .nrst_i, .conn_up_i, .link_wr_i, .link_from_host_i,
      .link_to_host_o, .def_wr_i, .def_idx_i, .def_data_i, .ain_valid_i, .ain_data_i,
      .ain_code_i, .loop_ua_i, .cfg_wr_i, .cfg_lo_i, .cfg_hi_i, .cfg_mode_i, .latch_en_i,
      .out_flags_i, .card_stat_i, .aout_cmd_o, .online_o);
   aio_host_model host (.clk_sys_i, .link_wr_o(link_wr_i), .link_from_host_o(link_from_host_i));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [LW_W-1:0] w(input int i);
      return link_to_host_o[i*LW_W +: LW_W];
   endfunction : w
   function automatic logic [7:0] fexp(input logic [15:0] code, input logic brk);
      return {5'h00, code <= LO, code >= HI, brk};
   endfunction : fexp
   function automatic logic [LW_W-1:0] ofexp(input logic [CH_NUM*OF_EXT_N-1:0] f);
      logic [LW_W-1:0] r;
      begin
         r = '0;
         for (int i = 0; i < CH_NUM; i++)
            r[i*FLD_W +: FLD_W] = {2'b00, f[i*OF_EXT_N +: OF_EXT_N]};
         return r;
      end
   endfunction : ofexp
   function automatic logic [CH_NUM*LW_W-1:0] rnd_cmd();
      logic [CH_NUM*LW_W-1:0] r;
      begin
         for (int i = 0; i < CH_NUM; i++)
            r[i*LW_W +: LW_W] = $random(seed) & 32'hBFFF_FFFF;
         return r;
      end
   endfunction : rnd_cmd
   task automatic step;
      begin
         @(posedge clk_sys_i);
         #1;
      end
   endtask : step
   task automatic chk(input logic [CH_NUM*LW_W-1:0] got, input logic [CH_NUM*LW_W-1:0] exp);
      begin
         n_tests++;
         if (got !== exp)
         begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask : chk
   task automatic setup(input int ch);
      begin
         cfg_wr_i[ch] = 1'b1;
         step;
         cfg_wr_i = 4'h0;
         step;
      end
   endtask : setup
   task automatic sample(input int ch, input logic [15:0] code, ua, input logic [7:0] fe);
      begin
         ain_code_i[ch*16 +: 16] = code;
         loop_ua_i[ch*16 +: 16] = ua;
         ain_data_i[ch*LW_W +: LW_W] = $random(seed);
         ain_valid_i[ch] = 1'b1;
         step;
         ain_valid_i = 4'h0;
         chk(w(LK_IN_DATA + ch), ain_data_i[ch*LW_W +: LW_W]);
         step;
         chk(w(LK_IN_STAT), {24'h0, fe} << (FLD_W * ch));
      end
   endtask : sample
   task automatic tally_and_finish;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, failures);
         if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4000) @(posedge clk_sys_i);
      failures++;
      tally_and_finish;
   end
   initial
   begin
      repeat (3) @(posedge clk_sys_i);
      for (k = 0; k < LW_NUM; k++)
         chk(w(k), 32'h0);
      #1 nrst_i = 1'b1;
      // Defaults back to back, then host words while offline
      for (k = 0; k < CH_NUM; k++)
      begin
         def_idx_i = k[1:0];
         def_data_i = $random(seed) & 32'hBFFF_FFFF;
         cmd[k*LW_W +: LW_W] = def_data_i;
         def_wr_i = 1'b1;
         step;
      end
      def_wr_i = 1'b0;
      host.send(rnd_cmd(), 32'hFFFF_FFFF);
      chk(aout_cmd_o, cmd);
      conn_up_i = 1'b1;
      step;
      chk(online_o, 1'b1);
      for (k = 0; k < 4; k++)
      begin
         cmd = rnd_cmd();
         host.send(cmd, 32'h0);
         chk(aout_cmd_o, cmd);
         chk(link_to_host_o[8*LW_W-1:4*LW_W], cmd);
      end
      for (k = 11; k < LW_NUM; k++)
         chk(w(k), 32'h0);
      n = {$random(seed)} % CH_NUM;
      out_flags_i = 24'($random(seed));
      card_stat_i = $random(seed);
      // Channel 0 always carries a bad float as well, so its hold check is reached
      host.send(cmd | 128'h7FC0_0001 | (128'h7FC0_0001 << (n * LW_W)), 32'h0);
      chk(aout_cmd_o, cmd);
      chk(w(LK_OUT_STAT) & 32'h4040_4040, 32'h40 | (32'h40 << (FLD_W * n)));
      chk(w(LK_OUT_STAT) & 32'hBFBF_BFBF, ofexp(out_flags_i));
      chk(w(LK_CARD_STAT), card_stat_i);
      for (n = 0; n < CH_NUM; n++)
      begin
         setup(n);
         for (k = 0; k < 6; k++)
            sample(n, tcode[k], tua[k], fexp(tcode[k], tbrk[k]));
      end
      n = 1;
      cfg_mode_i = 2'h1;
      setup(n);
      sample(n, 16'h8000, 16'h03E8, 8'h00);
      cfg_lo_i = HI;
      setup(n);
      chk(w(LK_IN_STAT), 32'h0000_0800);
      sample(n, HI, 16'h03E8, 8'h0A);
      cfg_lo_i = LO;
      setup(n);
      sample(n, 16'h8000, 16'h03E8, 8'h00);
      // Latched flag outlives its condition until released
      n = 3;
      cfg_mode_i = 2'h3;
      latch_en_i = 1'b1;
      setup(n);
      sample(n, HI, 16'h0DAC, 8'h02);
      sample(n, 16'h8000, 16'h0DAC, 8'h02);
      host.send(cmd, 32'h0200_0000);
      step;
      chk(w(LK_IN_STAT), 32'h0);
      conn_up_i = 1'b0;
      step;
      chk(online_o, 1'b0);
      host.send(rnd_cmd(), 32'h0);
      chk(aout_cmd_o, cmd);
      tally_and_finish;
   end
endmodule : aio_link_map_bench
